// ==== rtl/sits_regs.svh ====
// Offsets, reset values and encodings of the serial IRQ trigger and status block
`ifndef SITS_REGS_SVH
`define SITS_REGS_SVH

`define SITS_OFS_TRIGGER_SELECT 8'hE2
`define SITS_OFS_LEVEL_PENDING 8'hE4
`define SITS_RST_TRIGGER_SELECT 16'h0000
`define SITS_RST_LEVEL_PENDING 16'h0000
`define SITS_RST_FORWARD 16'h0000
`define SITS_RDATA_UNMAPPED 16'h0000
`define SITS_MODE_EDGE 1'b0
`define SITS_MODE_LEVEL 1'b1
`define SITS_BE_ALL 2'h3

`endif

// ==== rtl/sits_pkg.sv ====
// Types and helper functions of the serial IRQ trigger and status block
`default_nettype none

package sits_pkg;

   typedef logic [15:0] sits_slot_vec_t;
   typedef logic [7:0] sits_cfg_addr_t;
   typedef logic [1:0] sits_byte_en_t;

   // Expands the two byte enables into a 16-bit lane mask
   function automatic sits_slot_vec_t sits_be_mask(input sits_byte_en_t be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction

   // Merges written bytes into an old register value
   function automatic sits_slot_vec_t sits_merge(input sits_slot_vec_t old_val, input sits_slot_vec_t wdata,
                                                 input sits_byte_en_t be);
      return (old_val & ~sits_be_mask(be)) | (wdata & sits_be_mask(be));
   endfunction

endpackage

`default_nettype wire

// ==== rtl/sits_slot_if.sv ====
// Signals between the register front end and the per-slot latch
`default_nettype none

interface sits_slot_if import sits_pkg::*; ();
   sits_slot_vec_t mode;
   sits_slot_vec_t assert_ev;
   sits_slot_vec_t rearm;
   logic sync_clear;
   sits_slot_vec_t pending;
   sits_slot_vec_t forward;

   modport ctrl (output mode, output assert_ev, output rearm, output sync_clear,
                 input pending, input forward);
   modport latch (input mode, input assert_ev, input rearm, input sync_clear,
                  output pending, output forward);
endinterface

`default_nettype wire

// ==== rtl/sits_slot_latch.sv ====
// Per-slot level pending latch and interrupt forwarding
`default_nettype none
`include "sits_regs.svh"

module sits_slot_latch import sits_pkg::*; (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Slot signals
   sits_slot_if.latch slot
);

   sits_slot_vec_t lvl_hit;
   sits_slot_vec_t take;
   sits_slot_vec_t edge_ev;
   sits_slot_vec_t edge_sel;
   sits_slot_vec_t blocked;
   sits_slot_vec_t rearm_only;
   sits_slot_vec_t next_pending;
   sits_slot_vec_t next_forward;

   assign edge_sel = ~slot.mode;
   assign lvl_hit = slot.mode & slot.assert_ev;
   assign take = lvl_hit & (~slot.pending | slot.rearm); // [R4] [R8]
   assign edge_ev = slot.assert_ev & edge_sel; // [R5]
   assign blocked = slot.pending & slot.mode & ~slot.rearm;
   assign rearm_only = slot.rearm & ~slot.assert_ev;
   // Bitwise so that bit n always follows slot n; a set beats a re-arm
   assign next_pending = slot.sync_clear ? `SITS_RST_LEVEL_PENDING :
                         ((slot.pending & ~slot.rearm) | take); // [R6] [R7]
   assign next_forward = slot.sync_clear ? `SITS_RST_FORWARD : (edge_ev | take); // [R1] [R8]

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         slot.pending <= `SITS_RST_LEVEL_PENDING;
         slot.forward <= `SITS_RST_FORWARD;
      end else begin
         slot.pending <= next_pending;
         slot.forward <= next_forward;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   AST_LEVEL_SET: assert property ((lvl_hit != 16'h0000) && !slot.sync_clear |=> // [R4]
      ((slot.pending & $past(lvl_hit)) == $past(lvl_hit)))
      else $error("level assertion did not set its pending bit");
   AST_EDGE_NO_SET: assert property (1'b1 |=> // [R5]
      ((slot.pending & ~$past(slot.pending) & $past(edge_sel)) == 16'h0000))
      else $error("pending bit set on an edge slot");
   AST_REARM_CLEAR: assert property ((rearm_only != 16'h0000) |=> // [R6]
      ((slot.pending & $past(rearm_only)) == 16'h0000))
      else $error("re-armed pending bit did not clear");
   AST_SLOT_MAP: assert property (1'b1 |=> // [R7]
      ((slot.pending & ~$past(slot.pending) & ~$past(slot.assert_ev)) == 16'h0000))
      else $error("pending bit set without its own slot asserting");
   AST_NO_REFORWARD: assert property ((blocked != 16'h0000) |=> // [R8]
      ((slot.forward & $past(blocked)) == 16'h0000))
      else $error("pending level slot forwarded again");
   AST_EDGE_FORWARD: assert property ((edge_ev != 16'h0000) && !slot.sync_clear |=> // [R1]
      ((slot.forward & $past(edge_ev)) == $past(edge_ev)) ##1
      ((slot.forward & $past(edge_ev, 2) & ~$past(slot.assert_ev)) == 16'h0000))
      else $error("edge assertion not forwarded as one pulse");

   COV_LEVEL_SET: cover property ((lvl_hit != 16'h0000) ##1 (slot.pending != 16'h0000));
   COV_REARM_WITH_EVENT: cover property ((slot.rearm & lvl_hit & slot.pending) != 16'h0000);
   COV_EDGE_FORWARD: cover property ((edge_ev != 16'h0000) ##1 (slot.forward != 16'h0000));

endmodule

`default_nettype wire

// ==== rtl/sits_top.sv ====
// Serial IRQ trigger select and level pending registers with slot forwarding
`default_nettype none
`include "sits_regs.svh"

// How it works
// [R1] One edge/level select bit per slot
// [R2] Both registers sixteen bits, reset to zero
// [R3] Fundamental, global or power-on reset clears selects
// [R4] Level slot assertion sets its pending bit
// [R5] Edge slots never set a pending bit
// [R6] Writing one re-arms and clears pending bit
// [R7] Pending bit n belongs to slot n
// [R8] No re-forward while pending; zero writes ignored
module sits_top import sits_pkg::*; (
   // Clock and power-on reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Further reset sources
   input wire logic pcie_fund_reset_i,
   input wire logic global_reset_input_i,
   // Configuration access
   input wire logic [7:0] cfg_addr_i,
   input wire logic [1:0] cfg_be_i,
   input wire logic [15:0] cfg_wdata_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   output logic [15:0] cfg_rdata_o,
   output logic cfg_rack_o,
   // Decoded serial IRQ slot assertions
   input wire logic [15:0] slot_assert_i,
   // Slot state and forwarded interrupts
   output logic [15:0] slot_trigger_select_bit_o,
   output logic [15:0] slot_level_pending_bit_o,
   output logic [15:0] slot_forward_o
);

   sits_slot_if slot ();

   sits_slot_vec_t trigger;
   sits_slot_vec_t next_trigger;
   sits_slot_vec_t rd_sel;
   sits_slot_vec_t next_rdata;
   sits_slot_vec_t rearm_vec;
   logic sync_clear;
   logic hit_trig;
   logic hit_pend;
   logic wr_trig;
   logic wr_pend;
   logic post_rst;
   sits_slot_vec_t edge_req;
   sits_slot_vec_t lvl_fresh;
   sits_slot_vec_t lvl_blocked;
   sits_slot_vec_t rearm_hit;

   // Address decode
   assign hit_trig = (cfg_addr_i == `SITS_OFS_TRIGGER_SELECT);
   assign hit_pend = (cfg_addr_i == `SITS_OFS_LEVEL_PENDING);
   assign wr_trig = cfg_wr_i & hit_trig;
   assign wr_pend = cfg_wr_i & hit_pend;

   // Synchronous reset sources clear select, pending and forward like the power-on reset; the read path is not cleared
   assign sync_clear = pcie_fund_reset_i | global_reset_input_i; // [R3]

   // Trigger select register
   assign next_trigger = sync_clear ? `SITS_RST_TRIGGER_SELECT : // [R3]
                         wr_trig ? sits_merge(trigger, cfg_wdata_i, cfg_be_i) : trigger; // [R1]

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         trigger <= `SITS_RST_TRIGGER_SELECT; // [R2] [R3]
      end else begin
         trigger <= next_trigger;
      end
   end

   // Only written ones in enabled lanes re-arm; zeros do nothing
   assign rearm_vec = wr_pend ? (cfg_wdata_i & sits_be_mask(cfg_be_i)) : `SITS_RST_LEVEL_PENDING; // [R6] [R8]

   assign slot.mode = trigger;
   assign slot.assert_ev = slot_assert_i;
   assign slot.rearm = rearm_vec;
   assign slot.sync_clear = sync_clear;

   sits_slot_latch u_latch (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .slot(slot)
   );

   // Read path
   assign rd_sel = hit_trig ? trigger :
                   hit_pend ? slot.pending : `SITS_RDATA_UNMAPPED;
   assign next_rdata = cfg_rd_i ? rd_sel : `SITS_RDATA_UNMAPPED;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_rdata_o <= `SITS_RDATA_UNMAPPED;
         cfg_rack_o <= 1'b0;
      end else begin
         cfg_rdata_o <= next_rdata;
         cfg_rack_o <= cfg_rd_i;
      end
   end

   // Outputs straight from flip-flops
   assign slot_trigger_select_bit_o = trigger;
   assign slot_level_pending_bit_o = slot.pending;
   assign slot_forward_o = slot.forward;

   // Marks the first edge after reset release
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         post_rst <= 1'b1;
      end else begin
         post_rst <= 1'b0;
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   // Slot classes seen by the checks below
   assign edge_req = slot_assert_i & ~trigger;
   assign lvl_fresh = slot_assert_i & trigger & ~slot.pending;
   assign lvl_blocked = slot_assert_i & trigger & slot.pending & ~rearm_vec;
   assign rearm_hit = slot_assert_i & trigger & slot.pending & rearm_vec;

   AST_RESET_ZERO: assert property (post_rst |-> // [R2]
      (trigger == 16'h0000) && (slot.pending == 16'h0000) && (cfg_rdata_o == 16'h0000))
      else $error("registers not zero after reset");
   AST_TRIG_WRITE: assert property (wr_trig && (cfg_be_i == `SITS_BE_ALL) && !sync_clear |=> // [R1]
      (slot_trigger_select_bit_o == $past(cfg_wdata_i)))
      else $error("trigger select write not stored");
   AST_TRIG_HOLD: assert property (!wr_trig && !sync_clear |=> $stable(trigger)) // [R1]
      else $error("trigger select changed without a write");
   AST_SYNC_CLEAR: assert property (sync_clear |=> // [R3]
      (trigger == 16'h0000) && (slot.pending == 16'h0000) && (slot.forward == 16'h0000))
      else $error("reset input did not clear the block");
   AST_READ_TRIG: assert property (cfg_rd_i && hit_trig |=> cfg_rack_o && (cfg_rdata_o == $past(trigger))) // [R1]
      else $error("trigger select read returned wrong data");
   AST_READ_PEND: assert property (cfg_rd_i && hit_pend |=> // [R7]
      cfg_rack_o && (cfg_rdata_o == $past(slot.pending)))
      else $error("pending read returned wrong data");
   AST_READ_UNMAPPED: assert property (cfg_rd_i && !hit_trig && !hit_pend |=> // [R2]
      cfg_rack_o && (cfg_rdata_o == 16'h0000))
      else $error("unmapped read not zero");
   AST_ZERO_WRITE: assert property (wr_pend && (cfg_wdata_i == 16'h0000) && !sync_clear |=> // [R8]
      (($past(slot.pending) & ~slot.pending) == 16'h0000))
      else $error("zero write cleared a pending bit");
   AST_REARM_VIA_PORT: assert property (wr_pend && (cfg_be_i == `SITS_BE_ALL) && !sync_clear |=> // [R6]
      ((slot_level_pending_bit_o & $past(cfg_wdata_i) & ~$past(slot_assert_i)) == 16'h0000))
      else $error("write of one left pending bit set");

   // Reset and read path
   AST_RESET_QUIET: assert property (post_rst |-> (slot_forward_o == 16'h0000) && !cfg_rack_o) // [R2]
      else $error("forward or acknowledge active after reset");
   AST_RACK_PULSE: assert property (1'b1 |=> (cfg_rack_o == $past(cfg_rd_i))) // [R2]
      else $error("read acknowledge not one cycle after the read");
   AST_RDATA_IDLE: assert property (!cfg_rd_i |=> (cfg_rdata_o == 16'h0000)) // [R2]
      else $error("read data not zero without a read");
   AST_READ_OLD_TRIG: assert property (cfg_rd_i && wr_trig |=> (cfg_rdata_o == $past(trigger))) // [R1]
      else $error("read in a write cycle did not return the old value");
   AST_READ_IN_CLEAR: assert property (cfg_rd_i && sync_clear |=> cfg_rack_o) // [R3]
      else $error("read not answered while a reset input was high");
   AST_UNMAPPED_WRITE: assert property (cfg_wr_i && !hit_trig && !hit_pend && !sync_clear |=> // [R2]
      $stable(trigger) && (($past(slot_level_pending_bit_o) & ~slot_level_pending_bit_o) == 16'h0000))
      else $error("unmapped write changed a register");
   AST_CLEAR_PORTS: assert property (sync_clear |=> (slot_forward_o == 16'h0000) && // [R3]
      (slot_level_pending_bit_o == 16'h0000) && (slot_trigger_select_bit_o == 16'h0000))
      else $error("reset input left an output set");

   // Trigger select lanes
   AST_TRIG_LOW_LANE: assert property (wr_trig && (cfg_be_i == 2'h1) && !sync_clear |=> // [R1]
      (((slot_trigger_select_bit_o ^ $past(cfg_wdata_i)) & 16'h00FF) == 16'h0000) &&
      (((slot_trigger_select_bit_o ^ $past(trigger)) & 16'hFF00) == 16'h0000))
      else $error("low lane trigger write wrong");
   AST_TRIG_HIGH_LANE: assert property (wr_trig && (cfg_be_i == 2'h2) && !sync_clear |=> // [R1]
      (((slot_trigger_select_bit_o ^ $past(cfg_wdata_i)) & 16'hFF00) == 16'h0000) &&
      (((slot_trigger_select_bit_o ^ $past(trigger)) & 16'h00FF) == 16'h0000))
      else $error("high lane trigger write wrong");
   AST_TRIG_NO_LANE: assert property (wr_trig && (cfg_be_i == 2'h0) && !sync_clear |=> $stable(trigger)) // [R1]
      else $error("trigger write with no lanes changed the register");

   // Pending and forward per slot
   AST_PEND_ONLY_BY_WRITE: assert property (!wr_pend && !sync_clear |=> // [R6]
      (($past(slot_level_pending_bit_o) & ~slot_level_pending_bit_o) == 16'h0000))
      else $error("pending bit cleared without a write");
   AST_ZERO_LANE_PEND: assert property (wr_pend && (cfg_be_i == 2'h0) && !sync_clear |=> // [R8]
      (($past(slot_level_pending_bit_o) & ~slot_level_pending_bit_o) == 16'h0000))
      else $error("pending write with no lanes cleared a bit");
   AST_REARM_LANE_OFF: assert property (wr_pend && (cfg_be_i == 2'h1) && !sync_clear |=> // [R6]
      ((($past(slot_level_pending_bit_o) & ~slot_level_pending_bit_o) & 16'hFF00) == 16'h0000))
      else $error("write with high lane off cleared a high pending bit");
   AST_PEND_LEVEL_ONLY: assert property (1'b1 |=> // [R5]
      ((slot_level_pending_bit_o & ~$past(slot_level_pending_bit_o) & ~$past(trigger)) == 16'h0000))
      else $error("pending bit set on a slot in edge handling");
   AST_EDGE_NO_PEND_PORT: assert property ((edge_req != 16'h0000) |=> // [R5]
      ((slot_level_pending_bit_o & ~$past(slot_level_pending_bit_o) & $past(edge_req)) == 16'h0000))
      else $error("edge slot assertion set a pending bit");
   AST_EDGE_FWD_PORT: assert property ((edge_req != 16'h0000) && !sync_clear |=> // [R5]
      ((slot_forward_o & $past(edge_req)) == $past(edge_req)))
      else $error("edge slot assertion not forwarded");
   AST_FWD_OWN_SLOT: assert property (1'b1 |=> ((slot_forward_o & ~$past(slot_assert_i)) == 16'h0000)) // [R7]
      else $error("forward on a slot that did not assert");
   AST_LEVEL_FIRST: assert property ((lvl_fresh != 16'h0000) && !sync_clear |=> // [R4]
      ((slot_forward_o & $past(lvl_fresh)) == $past(lvl_fresh)) &&
      ((slot_level_pending_bit_o & $past(lvl_fresh)) == $past(lvl_fresh)))
      else $error("first level assertion not forwarded and latched");
   AST_LEVEL_BLOCKED: assert property ((lvl_blocked != 16'h0000) && !sync_clear |=> // [R8]
      ((slot_forward_o & $past(lvl_blocked)) == 16'h0000) &&
      ((slot_level_pending_bit_o & $past(lvl_blocked)) == $past(lvl_blocked)))
      else $error("pending level slot forwarded again or lost");
   AST_REARM_WITH_EVENT: assert property ((rearm_hit != 16'h0000) && !sync_clear |=> // [R6]
      ((slot_forward_o & $past(rearm_hit)) == $past(rearm_hit)) &&
      ((slot_level_pending_bit_o & $past(rearm_hit)) == $past(rearm_hit)))
      else $error("assertion in the re-arm cycle not forwarded");

   COV_TRIG_WRITE: cover property (wr_trig ##1 (trigger != 16'h0000));
   COV_REARM: cover property ((slot.pending != 16'h0000) ##1 wr_pend ##1 (slot.pending == 16'h0000));

endmodule

`default_nettype wire

// ==== verification/sits_agent.sv ====
// Partner model: secondary bus agents signalling decoded slot assertions
`default_nettype none

module sits_agent (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Requests from the bench, slow adds one cycle
   input wire logic [15:0] req_i,
   input wire logic slow_i,
   // Decoded slot assertions
   output logic [15:0] slot_assert_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] stage;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stage <= 16'h0000;
         slot_assert_o <= 16'h0000;
      end else begin
         stage <= req_i;
         slot_assert_o <= slow_i ? stage : req_i;
      end
   end
endmodule

`default_nettype wire

// ==== verification/sits_top_tb.sv ====
// Self-checking bench for the serial IRQ trigger and status block
`default_nettype none
`include "sits_regs.svh"

module sits_top_tb import sits_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i, rst_i, fund, glob, wr, rd, slow, rack;
   logic [7:0] addr;
   logic [1:0] be;
   logic [15:0] wdata, req, sa, rdata, trig, pend, fwd, lfsr, r1;
   sits_slot_vec_t m_trig, m_pend, m_fwd, m_rdata, bm, rearm;
   logic m_rack;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;

   sits_agent sits_agent_i (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .slow_i(slow), .slot_assert_o(sa));
   sits_top sits_top_i (.clock_i(clock_i), .rst_i(rst_i), .pcie_fund_reset_i(fund), .global_reset_input_i(glob),
      .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_rdata_o(rdata),
      .cfg_rack_o(rack), .slot_assert_i(sa), .slot_trigger_select_bit_o(trig), .slot_level_pending_bit_o(pend),
      .slot_forward_o(fwd));

   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic idle();
      {fund, glob, wr, rd, slow} <= 5'h00;
      addr <= 8'h00;
      be <= 2'h0;
      wdata <= 16'h0000;
      req <= 16'h0000;
   endtask

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   // Reference model, compared at every edge outside reset
   always @(posedge clock_i) begin
      if (rst_i) begin
         {m_trig, m_pend, m_fwd, m_rdata} = '0;
         m_rack = 1'b0;
      end else begin
         chk("trigger", m_trig, trig);
         chk("pending", m_pend, pend);
         chk("forward", m_fwd, fwd);
         chk("rdata", m_rdata, rdata);
         chk("rack", {15'h0000, m_rack}, {15'h0000, rack});
         bm = {{8{be[1]}}, {8{be[0]}}};
         m_rack = rd;
         m_rdata = !rd ? 16'h0000 : addr == `SITS_OFS_TRIGGER_SELECT ? m_trig :
                   addr == `SITS_OFS_LEVEL_PENDING ? m_pend : 16'h0000;
         rearm = (wr && addr == `SITS_OFS_LEVEL_PENDING) ? bm & wdata & m_pend : 16'h0000;
         m_fwd = sa & (~m_trig | ~m_pend | rearm);
         m_pend = (m_pend & ~rearm) | (sa & m_trig);
         if (wr && addr == `SITS_OFS_TRIGGER_SELECT) m_trig = (m_trig & ~bm) | (wdata & bm);
         if (fund || glob) {m_trig, m_pend, m_fwd} = '0;
      end
   end

   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         report_and_stop();
      end
   end

   initial begin
      rst_i = 1'b1;
      {fund, glob, wr, rd, slow, addr, be, wdata, req} = '0;
      lfsr = 16'hD239;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      for (int t = 0; t < 5; t++) begin
         if (t == 3) begin
            @(posedge clock_i);
            rst_i <= 1'b1;
            idle();
            repeat (2) @(posedge clock_i);
            rst_i <= 1'b0;
            @(posedge clock_i);
         end
         for (int c = 0; c < 400; c++) begin
            @(posedge clock_i);
            lfsr = nxt(lfsr);
            r1 = lfsr;
            lfsr = nxt(lfsr);
            addr <= r1[1:0] == 2'h0 ? 8'hE0 : r1[0] ? `SITS_OFS_TRIGGER_SELECT : `SITS_OFS_LEVEL_PENDING;
            be <= (t == 1) ? r1[3:2] : `SITS_BE_ALL;
            wdata <= lfsr;
            wr <= r1[4] & r1[5];
            rd <= r1[6];
            req <= r1 & lfsr;
            slow <= (t == 4);
            fund <= (r1[15:9] == 7'h00);
            glob <= (r1[15:9] == 7'h7F);
         end
         $display("test %0d done", t);
      end
      @(posedge clock_i);
      idle();
      @(posedge clock_i);
      report_and_stop();
   end
endmodule

`default_nettype wire
